// ==== rtl/dmr_pkg.sv ====
package dmr_pkg;

	// Command kinds seen on the controller's command bus
	typedef enum logic [2:0] {
		CMD_NONE,
		CMD_MRS,
		CMD_WRITE,
		CMD_READ,
		CMD_REFRESH,
		CMD_SR_ENTRY,
		CMD_SR_EXIT
	} dmr_cmd_e;

	typedef enum logic {
		SR_IDLE,
		SR_ACTIVE
	} dmr_sr_e;

	localparam int BA_W   = 3;
	localparam int ADDR_W = 13;

	// One decoded command, carried from the link domain by handshake
	typedef struct packed {
		dmr_cmd_e            kind;
		logic [BA_W-1:0]     ba;
		logic [ADDR_W-1:0]   addr;
	} dmr_cmd_s;

	// Termination presented to the data-bus pads
	typedef struct packed {
		logic       isWrite;
		logic [2:0] code;
	} dmr_term_s;

	// Bank address of each mode register set target
	localparam logic [BA_W-1:0] BA_MR2 = 3'h2;
	localparam logic [BA_W-1:0] BA_MR3 = 3'h3;

	// Second mode register fields
	localparam int MR2_PARTIAL_ARRAY_SELF_REFRESH_LSB   = 0;
	localparam int MR2_CWL_LSB    = 3;
	localparam int MR2_SRT_BIT    = 7;
	localparam int MR2_RTT_WR_LSB = 9;
	localparam logic [1:0] RTT_WR_OFF      = 2'h0;
	localparam logic [1:0] RTT_WR_RESERVED = 2'h3;

	// Third mode register fields
	localparam int MR3_LOC_LSB    = 0;
	localparam int MR3_MPR_EN_BIT = 2;

	// Register bus byte offsets
	localparam logic [3:0] OFS_CTRL   = 4'h0;
	localparam logic [3:0] OFS_MR2    = 4'h4;
	localparam logic [3:0] OFS_MR3    = 4'h8;
	localparam logic [3:0] OFS_STATUS = 4'hC;

	// Control register layout and reset values
	localparam int CTRL_WL_BIT  = 0;
	localparam int CTRL_NOM_LSB = 1;
	localparam logic       CTRL_WL_RST  = 1'b0;
	localparam logic [2:0] CTRL_NOM_RST = 3'h0;

	// Status register layout
	localparam int ST_SR_BIT   = 0;
	localparam int ST_OVT_BIT  = 1;
	localparam int ST_LOST_LSB = 8;

	// Self refresh pacing at the 40 MHz system clock
	localparam int CLK_PERIOD_NS  = 25;
	localparam int REFI_NORMAL_NS = 7800;
	localparam int REFI_DOUBLE_NS = 3900;
	localparam int REF_CNT_W      = 9;
	localparam logic [REF_CNT_W-1:0] REFI_NORMAL_CYC =
		REF_CNT_W'(REFI_NORMAL_NS / CLK_PERIOD_NS);
	localparam logic [REF_CNT_W-1:0] REFI_DOUBLE_CYC =
		REF_CNT_W'(REFI_DOUBLE_NS / CLK_PERIOD_NS);

	localparam logic [7:0] ALL_BANKS = 8'hFF;

endpackage

// ==== rtl/dmr_link_decode.sv ====
`timescale 1ns/100ps
module dmr_link_decode
	import dmr_pkg::*;
(
	input  wire logic              clkLink,
	input  wire logic              sys_rst,
	input  wire logic              csN,
	input  wire logic              rasN,
	input  wire logic              casN,
	input  wire logic              weN,
	input  wire logic              cke,
	input  wire logic [BA_W-1:0]   ba,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic              ackTgl,
	output logic                   reqTgl,
	output dmr_cmd_s               cmdOut
);

	logic [1:0] rstPipe;
	logic [1:0] ackSync;
	logic       pend_q;
	logic       srLink_q;
	logic       rstLink;
	dmr_cmd_e   kindNow;

	// Reset reaches this domain through two flops of its own
	always_ff @(posedge clkLink) begin
		rstPipe <= {rstPipe[0], sys_rst};
	end
	assign rstLink = rstPipe[1];

	always_comb begin
		kindNow = CMD_NONE;
		if (!csN) begin
			case ({rasN, casN, weN})
				3'b000:  kindNow = CMD_MRS;
				3'b001:  kindNow = cke ? CMD_REFRESH : CMD_SR_ENTRY;
				3'b100:  kindNow = CMD_WRITE;
				3'b101:  kindNow = CMD_READ;
				default: kindNow = CMD_NONE;
			endcase
		end
		if (srLink_q && cke)
			kindNow = CMD_SR_EXIT;
	end

	// A command arriving while one is still in flight is dropped
	always_ff @(posedge clkLink) begin
		if (rstLink) begin
			ackSync  <= 2'b00;
			pend_q   <= 1'b0;
			reqTgl   <= 1'b0;
			srLink_q <= 1'b0;
			cmdOut   <= '0;
		end else begin
			ackSync <= {ackSync[0], ackTgl};
			if (pend_q && ackSync[1] == reqTgl)
				pend_q <= 1'b0;
			else if (!pend_q && kindNow != CMD_NONE) begin
				pend_q <= 1'b1;
				reqTgl <= ~reqTgl;
				cmdOut <= '{kind: kindNow, ba: ba, addr: addr};
			end
			if (!pend_q && kindNow == CMD_SR_ENTRY)
				srLink_q <= 1'b1;
			else if (!pend_q && kindNow == CMD_SR_EXIT)
				srLink_q <= 1'b0;
		end
	end

	default clocking @(posedge clkLink); endclocking
	default disable iff (rstLink);

	sequence mrsOnPins;
		!csN && !rasN && !casN && !weN && !pend_q && !(srLink_q && cke);
	endsequence

	AST_MRS_DECODE: assert property (mrsOnPins |=> pend_q && cmdOut.kind == CMD_MRS &&
		cmdOut.ba == $past(ba) && cmdOut.addr == $past(addr))
		else $error("mode register set not captured from pins");

endmodule

// ==== rtl/dmr_mode_ctrl.sv ====
// The register addresses and the Avalon-MM slave port were decided locally.
`timescale 1ns/100ps
// Function
// - Dynamic write termination comes from second mode register bits A10:A9.
// - Termination switches to write value on writes without further commands.
// - Write termination applies even when nominal termination is off.
// - Write leveling uses nominal termination only, never write termination.
// - Second mode register bit 7 enables extended-range self refresh.
// - Bit clear: self refresh runs at normal rate, fine up to 85C.
// - Bit set: self refresh rate doubles regardless of case temperature.
// - All command strobes low, BA=011 selects third mode register write.
// - Pattern location bits ignored while pattern function is off.
// - Predefined pattern is offered for read capture calibration.
// - Partial self refresh keeps only selected banks; others are lost.
module dmr_mode_ctrl
	import dmr_pkg::*;
#(
	parameter int          WRITE_TERM_CYC = 8,
	parameter logic [15:0] MPR_PATTERN    = 16'h55AA
)(
	input  wire logic              clk_sys,
	input  wire logic              sys_rst,
	input  wire logic              clkEn,
	input  wire logic [3:0]        avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	input  wire logic [3:0]        avs_byteenable,
	output logic [31:0]            avs_readdata,
	output logic                   avs_waitrequest,
	input  wire logic              clkLink,
	input  wire logic              csN,
	input  wire logic              rasN,
	input  wire logic              casN,
	input  wire logic              weN,
	input  wire logic              cke,
	input  wire logic [BA_W-1:0]   ba,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic              caseTempHigh,
	output dmr_term_s              termOut,
	output logic                   selfRefreshActive,
	output logic                   selfRefreshTick,
	output logic [7:0]             bankRetain,
	output logic                   patternValid,
	output logic [15:0]            patternData,
	output logic                   arrayReadReq
);

	localparam int WCNT_W = $clog2(WRITE_TERM_CYC + 1);

	logic                 reqTgl;
	logic                 ackTgl_q;
	logic [2:0]           reqSync_q;
	logic [1:0]           tempSync_q;
	dmr_cmd_s             linkCmd;
	logic                 writeLevel_q;
	logic [2:0]           nomTerm_q;
	logic [1:0]           rttWr_q;
	logic                 srtEn_q;
	logic [2:0]           cwl_q;
	logic [2:0]           partial_array_self_refresh_q;
	logic                 mprEn_q;
	logic [1:0]           mprLoc_q;
	dmr_sr_e              srState_q;
	logic [WCNT_W-1:0]    wrCnt_q;
	logic [REF_CNT_W-1:0] refCnt_q;
	logic [7:0]           lostBanks_q;
	logic                 overTemp_q;

	dmr_link_decode u_link (
		.clkLink (clkLink),
		.sys_rst (sys_rst),
		.csN     (csN),
		.rasN    (rasN),
		.casN    (casN),
		.weN     (weN),
		.cke     (cke),
		.ba      (ba),
		.addr    (addr),
		.ackTgl  (ackTgl_q),
		.reqTgl  (reqTgl),
		.cmdOut  (linkCmd)
	);

	// Command arrival; the struct is held stable by the link until acked
	wire cmdEvt   = clkEn && (reqSync_q[1] != reqSync_q[2]);
	wire isMrs    = cmdEvt && linkCmd.kind == CMD_MRS;
	wire mr2Wr    = isMrs && linkCmd.ba == BA_MR2;
	wire mr3Wr    = isMrs && linkCmd.ba == BA_MR3;
	wire wrEvt    = cmdEvt && linkCmd.kind == CMD_WRITE;
	wire rdEvt    = cmdEvt && linkCmd.kind == CMD_READ;
	wire srEntry  = cmdEvt && linkCmd.kind == CMD_SR_ENTRY;
	wire srExit   = cmdEvt && linkCmd.kind == CMD_SR_EXIT;
	wire srActive = srState_q == SR_ACTIVE;

	// Register bus decode
	wire busReq   = clkEn && (avs_read || avs_write) && avs_waitrequest;
	// Write lands on the edge that completes the transfer, not on the first one
	wire busWr    = clkEn && avs_write && !avs_waitrequest;
	wire ctrlWr   = busWr && avs_address == OFS_CTRL && avs_byteenable[0];
	wire statWr   = busWr && avs_address == OFS_STATUS;
	wire clrOvt   = statWr && avs_byteenable[0] && avs_writedata[ST_OVT_BIT];
	wire [7:0] clrLost = (statWr && avs_byteenable[1]) ?
		avs_writedata[ST_LOST_LSB +: 8] : 8'h00;

	wire [31:0] ctrlWord = {28'h0, nomTerm_q, writeLevel_q};
	wire [31:0] mr2Word  = {21'h0, rttWr_q, 1'b0, srtEn_q, 1'b0, cwl_q, partial_array_self_refresh_q};
	wire [31:0] mr3Word  = {29'h0, mprEn_q, mprLoc_q};
	wire [31:0] statWord = {16'h0, lostBanks_q, 6'h0, overTemp_q, srActive};
	wire [31:0] rdMux    = (avs_address == OFS_CTRL)   ? ctrlWord :
	                       (avs_address == OFS_MR2)    ? mr2Word  :
	                       (avs_address == OFS_MR3)    ? mr3Word  :
	                       (avs_address == OFS_STATUS) ? statWord : 32'h0;

	function automatic logic [7:0] pasrMaskOf(input logic [2:0] code);
		case (code)
			3'h0:    pasrMaskOf = 8'hFF;
			3'h1:    pasrMaskOf = 8'h0F;
			3'h2:    pasrMaskOf = 8'h03;
			3'h3:    pasrMaskOf = 8'h01;
			3'h4:    pasrMaskOf = 8'hFC;
			3'h5:    pasrMaskOf = 8'hF0;
			3'h6:    pasrMaskOf = 8'hC0;
			default: pasrMaskOf = 8'h80;
		endcase
	endfunction
	wire [7:0] pasrMask = pasrMaskOf(partial_array_self_refresh_q);

	wire wrTermOn   = rttWr_q != RTT_WR_OFF && rttWr_q != RTT_WR_RESERVED;
	wire wrWindow   = wrCnt_q != '0;
	wire useWrTerm  = wrWindow && wrTermOn && !writeLevel_q;
	wire [REF_CNT_W-1:0] refLimit = srtEn_q ? REFI_DOUBLE_CYC : REFI_NORMAL_CYC;
	wire refDue = srActive && refCnt_q >= refLimit - REF_CNT_W'(1);

	// Bus slave: answers one cycle after the request
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0;
		end else if (clkEn) begin
			avs_waitrequest <= !busReq;
			if (busReq && avs_read)
				avs_readdata <= rdMux;
		end
	end

	// Handshake receive and temperature pin synchroniser
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			reqSync_q  <= 3'h0;
			ackTgl_q   <= 1'b0;
			tempSync_q <= 2'h0;
		end else if (clkEn) begin
			reqSync_q  <= {reqSync_q[1:0], reqTgl};
			ackTgl_q   <= reqSync_q[1];
			tempSync_q <= {tempSync_q[0], caseTempHigh};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			writeLevel_q <= CTRL_WL_RST;
			nomTerm_q    <= CTRL_NOM_RST;
		end else if (ctrlWr) begin
			writeLevel_q <= avs_writedata[CTRL_WL_BIT];
			nomTerm_q    <= avs_writedata[CTRL_NOM_LSB +: 3];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rttWr_q <= RTT_WR_OFF;
			srtEn_q <= 1'b0;
			cwl_q   <= 3'h0;
			partial_array_self_refresh_q  <= 3'h0;
		end else if (mr2Wr) begin
			rttWr_q <= linkCmd.addr[MR2_RTT_WR_LSB +: 2];
			srtEn_q <= linkCmd.addr[MR2_SRT_BIT];
			cwl_q   <= linkCmd.addr[MR2_CWL_LSB +: 3];
			partial_array_self_refresh_q  <= linkCmd.addr[MR2_PARTIAL_ARRAY_SELF_REFRESH_LSB +: 3];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			mprEn_q  <= 1'b0;
			mprLoc_q <= 2'h0;
		end else if (mr3Wr) begin
			mprEn_q  <= linkCmd.addr[MR3_MPR_EN_BIT];
			mprLoc_q <= linkCmd.addr[MR3_LOC_LSB +: 2];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			wrCnt_q <= '0;
			termOut <= '{isWrite: 1'b0, code: CTRL_NOM_RST};
		end else if (clkEn) begin
			if (wrEvt)
				wrCnt_q <= WCNT_W'(WRITE_TERM_CYC);
			else if (wrWindow)
				wrCnt_q <= wrCnt_q - WCNT_W'(1);
			termOut <= useWrTerm ? '{isWrite: 1'b1, code: {1'b0, rttWr_q}}
			                     : '{isWrite: 1'b0, code: nomTerm_q};
		end
	end

	// doubled pacing follows the bit alone, not the temperature
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			srState_q         <= SR_IDLE;
			selfRefreshActive <= 1'b0;
			selfRefreshTick   <= 1'b0;
			refCnt_q          <= '0;
		end else if (clkEn) begin
			case (srState_q)
				SR_IDLE:   if (srEntry) srState_q <= SR_ACTIVE;
				SR_ACTIVE: if (srExit) srState_q <= SR_IDLE;
				default:   srState_q <= SR_IDLE;
			endcase
			selfRefreshActive <= srEntry || (srActive && !srExit);
			selfRefreshTick   <= refDue;
			refCnt_q          <= (refDue || !srActive) ? '0 : refCnt_q + REF_CNT_W'(1);
		end
	end

	// lost banks; a new loss wins over a clear
	// misuse caught as sticky over-temperature flag
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			bankRetain  <= ALL_BANKS;
			lostBanks_q <= 8'h00;
			overTemp_q  <= 1'b0;
		end else if (clkEn) begin
			bankRetain  <= (srEntry || (srActive && !srExit)) ? pasrMask : ALL_BANKS;
			lostBanks_q <= (lostBanks_q & ~clrLost) | (srEntry ? ~pasrMask : 8'h00);
			overTemp_q  <= (overTemp_q && !clrOvt) ||
			               (srActive && tempSync_q[1] && !srtEn_q);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			patternValid <= 1'b0;
			patternData  <= 16'h0000;
			arrayReadReq <= 1'b0;
		end else if (clkEn) begin
			patternValid <= rdEvt && mprEn_q;
			arrayReadReq <= rdEvt && !mprEn_q;
			if (rdEvt && mprEn_q)
				patternData <= (mprLoc_q == 2'h0) ? MPR_PATTERN : 16'h0000;
		end
	end

	// Helper: cycles since the last self refresh tick
	logic [REF_CNT_W:0] gapCnt_q;
	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			gapCnt_q <= '0;
		else if (clkEn)
			gapCnt_q <= (!srActive || selfRefreshTick) ? '0 : gapCnt_q + (REF_CNT_W+1)'(1);
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	sequence wrTermSeq;
		wrEvt && wrTermOn && !writeLevel_q ##1 clkEn && !writeLevel_q;
	endsequence
	sequence busAnswer;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence

	AST_MR2_LATCH: assert property (mr2Wr |=> rttWr_q == $past(linkCmd.addr[10:9]))
		else $error("write termination field not taken from A10:A9");
	AST_WR_TERM: assert property (wrTermSeq |=> termOut.isWrite &&
		termOut.code == {1'b0, rttWr_q})
		else $error("write termination not applied after write");
	AST_WL_NOMINAL: assert property (writeLevel_q && clkEn |=> !termOut.isWrite)
		else $error("write termination used during write leveling");
	AST_SRT_DOUBLE: assert property (selfRefreshTick && srtEn_q &&
		$past(srtEn_q, 2) |-> gapCnt_q <= (REF_CNT_W+1)'(REFI_DOUBLE_CYC))
		else $error("self refresh not doubled with extended range set");
	AST_SRT_NORMAL: assert property (selfRefreshTick |->
		gapCnt_q <= (REF_CNT_W+1)'(REFI_NORMAL_CYC))
		else $error("self refresh interval too long");
	AST_MPR_READ: assert property (rdEvt && mprEn_q |=> patternValid && !arrayReadReq)
		else $error("read not redirected to pattern");
	AST_MPR_OFF: assert property (rdEvt && !mprEn_q |=> arrayReadReq && !patternValid)
		else $error("pattern returned while function off");
	AST_PARTIAL_ARRAY_SELF_REFRESH_LOSS: assert property (srEntry |=> (lostBanks_q | bankRetain) == ALL_BANKS)
		else $error("bank outside retained range not marked lost");
	AST_MR_HOLD: assert property (!mr2Wr && !mr3Wr |=> $stable(rttWr_q) &&
		$stable(srtEn_q) && $stable(partial_array_self_refresh_q) && $stable(mprEn_q))
		else $error("mode setting changed without mode register set");
	AST_BUS_ANSWER: assert property (busReq |=> busAnswer)
		else $error("bus answer not one cycle wide");

endmodule

// ==== tb/dmr_ctrl_model.sv ====
`timescale 1ns/100ps
module dmr_ctrl_model
	import dmr_pkg::*;
(
	input  wire logic         clkLink,
	input  wire logic         tempHigh,
	output logic              csN,
	output logic              rasN,
	output logic              casN,
	output logic              weN,
	output logic              cke,
	output logic [BA_W-1:0]   ba,
	output logic [ADDR_W-1:0] addr
);
	logic srtQ;

	initial begin
		{csN, rasN, casN, weN, cke} = 5'h1F;
		ba = 3'h0;
		addr = 13'h0000;
		srtQ = 1'b0;
	end

	task automatic issue(input dmr_cmd_e k, input logic [2:0] b, input logic [12:0] a);
		logic [2:0]  strobes;
		logic [12:0] aOut;
		// hot device: self refresh only with extended range
		if (k == CMD_SR_ENTRY && tempHigh && !srtQ) return;
		// strobe encoding of each command kind
		strobes = (k == CMD_MRS) ? 3'h0 : (k == CMD_WRITE) ? 3'h4 :
			(k == CMD_READ) ? 3'h5 : 3'h1;
		// reserved third register bits sent as zero
		aOut = (b == BA_MR3) ? (a & 13'h0007) : a;
		if (k == CMD_MRS && b == BA_MR2) srtQ = a[MR2_SRT_BIT];
		@(posedge clkLink);
		if (k == CMD_SR_EXIT) cke <= 1'b1;
		else begin
			csN <= 1'b0;
			{rasN, casN, weN} <= strobes;
			ba <= b;
			addr <= aOut;
			cke <= (k != CMD_SR_ENTRY);
		end
		@(posedge clkLink);
		csN <= 1'b1;
		{rasN, casN, weN} <= 3'h7;
		// Idle address keeps moving so nothing relies on stale pins
		addr <= ~aOut;
		repeat (7) begin
			@(posedge clkLink);
			addr <= ~addr;
		end
	endtask
endmodule

// ==== tb/dram_mode_reg_two_three_control_bench.sv ====
`timescale 1ns/100ps
module dram_mode_reg_two_three_control_bench
	import dmr_pkg::*;
;
	typedef struct {
		logic [2:0]  b;
		logic [12:0] a;
		logic [3:0]  ofs;
		logic [31:0] exp;
	} dmr_row_s;

	logic clk_sys, clkLink, sys_rst, avs_read, avs_write, avs_waitrequest;
	logic csN, rasN, casN, weN, cke, clrFlags, sawPat, sawArr, sawWr, tempHi;
	logic selfRefreshActive, selfRefreshTick, patternValid, arrayReadReq;
	logic [3:0]        avs_address;
	logic [31:0]       avs_writedata, avs_readdata, d;
	logic [BA_W-1:0]   ba;
	logic [ADDR_W-1:0] addr;
	logic [7:0]        bankRetain;
	logic [15:0]       patternData, patQ;
	logic [2:0]        wrCode;
	dmr_term_s         termOut;
	int                errors, checks_done, g;
	dmr_row_s rows [6] = '{
		'{3'h2, 13'h06BF, OFS_MR2, 32'h6BF}, '{3'h2, 13'h0281, OFS_MR2, 32'h281},
		'{3'h0, 13'h1234, OFS_MR2, 32'h281}, '{3'h3, 13'h0006, OFS_MR3, 32'h6},
		'{3'h3, 13'h0000, OFS_MR3, 32'h0}, '{3'h1, 13'h0000, 4'h2, 32'h0}};

	dmr_mode_ctrl dmr_mode_ctrl_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .clkEn(1'b1),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .clkLink(clkLink), .csN(csN), .rasN(rasN),
		.casN(casN), .weN(weN), .cke(cke), .ba(ba), .addr(addr), .caseTempHigh(tempHi),
		.termOut(termOut), .selfRefreshActive(selfRefreshActive),
		.selfRefreshTick(selfRefreshTick), .bankRetain(bankRetain),
		.patternValid(patternValid), .patternData(patternData), .arrayReadReq(arrayReadReq));

	dmr_ctrl_model dmr_ctrl_model_inst (.clkLink(clkLink), .tempHigh(tempHi), .csN(csN),
		.rasN(rasN), .casN(casN), .weN(weN), .cke(cke), .ba(ba), .addr(addr));

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	initial begin
		clkLink = 1'b0;
		#7;
		forever #24 clkLink = ~clkLink;
	end

	// Sticky capture of the one-cycle pattern and array-read pulses and of the write termination window
	always @(posedge clk_sys) begin
		if (clrFlags) {sawPat, sawArr, sawWr} <= 3'h0;
		if (patternValid === 1'b1) begin
			sawPat <= 1'b1;
			patQ <= patternData;
		end
		if (arrayReadReq === 1'b1) sawArr <= 1'b1;
		if (termOut.isWrite === 1'b1) begin
			sawWr <= 1'b1;
			wrCode <= termOut.code;
		end
	end

	task close_out;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			errors++;
		end
	endtask
	task hang;
		$display("wrong value at %0t: got %h expected %h", $time, 32'h0, 32'h1);
		errors++;
		close_out;
	endtask
	task busXfer(input logic wr, input logic [3:0] ad, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk_sys);
		avs_read <= !wr;
		avs_write <= wr;
		avs_address <= ad;
		avs_writedata <= wd;
		do begin
			@(posedge clk_sys);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		d = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 50) hang;
	endtask
	task clearFlags;
		@(posedge clk_sys) clrFlags <= 1'b1;
		@(posedge clk_sys) clrFlags <= 1'b0;
	endtask
	task cmd(input dmr_cmd_e k, input logic [2:0] b, input logic [12:0] a);
		dmr_ctrl_model_inst.issue(k, b, a);
	endtask
	// Gap in cycles between the first two ticks
	task tickGap;
		int n, t, last;
		n = 0; t = 0; last = 0;
		while (t < 2 && n < 1000) begin
			@(posedge clk_sys);
			n++;
			if (selfRefreshTick === 1'b1) begin
				t++;
				g = n - last;
				last = n;
			end
		end
		if (t < 2) hang;
	endtask

	initial begin
		errors = 0; checks_done = 0; sys_rst = 1'b1; clrFlags = 1'b0; tempHi = 1'b0;
		avs_read = 1'b0; avs_write = 1'b0; avs_address = 4'h0; avs_writedata = 32'h0;
		repeat (20) @(posedge clk_sys);
		sys_rst <= 1'b0;
		repeat (4) @(posedge clkLink);
		for (int i = 0; i < 4; i++) begin
			busXfer(1'b0, 4'(4 * i), 32'h0);
			chk(d, 32'h0);
		end
		chk({24'h0, bankRetain}, 32'hFF);
		chk({28'h0, termOut}, 32'h0);
		busXfer(1'b1, 4'h2, 32'hFFFFFFFF);
		for (int i = 0; i < 6; i++) begin
			cmd(CMD_MRS, rows[i].b, rows[i].a);
			busXfer(1'b0, rows[i].ofs, 32'h0);
			chk(d, rows[i].exp);
		end
		for (int r = 1; r < 3; r++) begin
			cmd(CMD_MRS, BA_MR2, 13'(r << MR2_RTT_WR_LSB));
			clearFlags;
			cmd(CMD_WRITE, 3'h0, 13'h0000);
			chk({31'h0, sawWr}, 32'h1);
			chk({29'h0, wrCode}, 32'(r));
		end
		busXfer(1'b1, OFS_CTRL, 32'h5);
		busXfer(1'b0, OFS_CTRL, 32'h0);
		chk(d, 32'h5);
		clearFlags;
		cmd(CMD_WRITE, 3'h0, 13'h0000);
		chk({31'h0, sawWr}, 32'h0);
		chk({28'h0, termOut}, 32'h2);
		busXfer(1'b1, OFS_CTRL, 32'h0);
		cmd(CMD_MRS, BA_MR3, 13'h0004);
		clearFlags;
		cmd(CMD_READ, 3'h0, 13'h0000);
		chk({30'h0, sawPat, sawArr}, 32'h2);
		chk({16'h0, patQ}, 32'h55AA);
		cmd(CMD_MRS, BA_MR3, 13'h0005);
		clearFlags;
		cmd(CMD_READ, 3'h0, 13'h0000);
		chk({15'h0, sawPat, patQ}, 32'h10000);
		cmd(CMD_MRS, BA_MR3, 13'h0003);
		clearFlags;
		cmd(CMD_READ, 3'h0, 13'h0000);
		chk({30'h0, sawPat, sawArr}, 32'h1);
		for (int s = 0; s < 2; s++) begin
			cmd(CMD_MRS, BA_MR2, s ? 13'h0080 : 13'h0001);
			// Hot entry is only allowed with extended range set
			tempHi <= (s == 1);
			cmd(CMD_SR_ENTRY, 3'h0, 13'h0000);
			tempHi <= 1'b1;
			tickGap;
			chk(32'(g), s ? 32'(REFI_DOUBLE_CYC) : 32'(REFI_NORMAL_CYC));
			chk({24'h0, bankRetain}, s ? 32'hFF : 32'h0F);
			busXfer(1'b0, OFS_STATUS, 32'h0);
			chk(d, s ? 32'h0001 : 32'hF003);
			tempHi <= 1'b0;
			cmd(CMD_SR_EXIT, 3'h0, 13'h0000);
			chk({31'h0, selfRefreshActive}, 32'h0);
			busXfer(1'b1, OFS_STATUS, 32'hFF02);
		end
		close_out;
	end
endmodule
